// File: rtl/asc_consts.vh
// Constants for the asynchronous static memory controller.
// Assumes a 40 MHz system clock; included by bare name.
`ifndef ASC_CONSTS_VH
`define ASC_CONSTS_VH

// ****************************************************************
// Geometry
// ****************************************************************
`define ASC_AW 13
`define ASC_DW 8

// ****************************************************************
// Timing (ns) and derived cycle counts at 25 ns per clock
// ****************************************************************
`define ASC_CLK_NS 25
// Read cycle time, slow grade at low supply, least time
`define ASC_T_READ_CYCLE_NS 500
// Write pulse width, least time
`define ASC_T_WRITE_PULSE_NS 250
// Data setup before end of write, least time
`define ASC_T_DATA_SETUP_NS 180
// Output drive release after drive enable removal, longest time
`define ASC_T_OUT_DISABLE_NS 120
// Rounded-up cycle counts
`define ASC_CYC(ns) (((ns) + `ASC_CLK_NS - 1) / `ASC_CLK_NS)
`define ASC_RD_CYC `ASC_CYC(`ASC_T_READ_CYCLE_NS)
`define ASC_WR_CYC `ASC_CYC(`ASC_T_WRITE_PULSE_NS)
`define ASC_DS_CYC `ASC_CYC(`ASC_T_DATA_SETUP_NS)
`define ASC_TA_CYC `ASC_CYC(`ASC_T_OUT_DISABLE_NS)
`define ASC_CNT_W 6
`define ASC_CNT_ONE 6'h01
`define ASC_CNT_ZERO 6'h00

`endif

// File: rtl/asc_timer.v
// Down counter that times the phases of a memory access.
// Assumes a load pulse with a nonzero count; done is a level.
`include "asc_consts.vh"

module asc_timer (
  // Clock and reset
  input wire clk_sys_i,
  input wire resetn_i,
  // Control
  input wire load_i,
  input wire [`ASC_CNT_W-1:0] count_i,
  // Status
  output wire done_o
);

  reg [`ASC_CNT_W-1:0] cnt_q;

  // ****************************************************************
  // Counter
  // ****************************************************************
  always @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cnt_q <= `ASC_CNT_ZERO;
    end else if (load_i) begin
      cnt_q <= count_i;
    end else if (cnt_q != `ASC_CNT_ZERO) begin
      cnt_q <= cnt_q - `ASC_CNT_ONE;
    end
  end

  // Idle counter reads as expired
  assign done_o = (cnt_q == `ASC_CNT_ZERO);

endmodule // asc_timer

// File: rtl/asc_ctrl.v
// Controller that drives an 8K x 8 asynchronous static memory.
// Assumes the memory pins are wired straight to the ports below and
// the bench resolves the shared data wire from data_oe_n_o.
`include "asc_consts.vh"

module asc_ctrl (
  // Clock and reset
  input wire clk_sys_i,
  input wire resetn_i,
  // User request
  input wire req_i,
  input wire req_write_i,
  input wire [`ASC_AW-1:0] req_addr_i,
  input wire [`ASC_DW-1:0] req_wdata_i,
  output wire req_ready_o,
  output reg [`ASC_DW-1:0] rd_data_o,
  output reg rd_valid_o,
  output reg wr_done_o,
  // Supply status
  input wire supply_ok_i,
  output wire retention_o,
  // Memory pins
  output reg [`ASC_AW-1:0] word_address_o,
  output reg chip_select_low_o,
  output reg chip_select_high_o,
  output reg read_drive_enable_n_o,
  output reg write_strobe_n_o,
  output reg [`ASC_DW-1:0] data_lines_o,
  output reg data_oe_n_o,
  input wire [`ASC_DW-1:0] data_lines_i
);

  // ****************************************************************
  // States
  // ****************************************************************
  localparam [2:0] ST_RET = 3'h0;
  localparam [2:0] ST_WAKE = 3'h1;
  localparam [2:0] ST_IDLE = 3'h2;
  localparam [2:0] ST_READ = 3'h3;
  localparam [2:0] ST_WRITE = 3'h4;
  localparam [2:0] ST_TURN = 3'h5;

  reg [2:0] state_q;
  reg [2:0] state_d;
  reg tmr_load;
  reg [`ASC_CNT_W-1:0] tmr_count;
  wire tmr_done;

  // Cycle count helper, used by several phases
  function [`ASC_CNT_W-1:0] cyc;
    input integer n;
    begin
      cyc = n[`ASC_CNT_W-1:0];
    end
  endfunction

  asc_timer u_timer (
    .clk_sys_i(clk_sys_i),
    .resetn_i(resetn_i),
    .load_i(tmr_load),
    .count_i(tmr_count),
    .done_o(tmr_done)
  );

  assign req_ready_o = (state_q == ST_IDLE) && supply_ok_i;
  assign retention_o = (state_q == ST_RET);

  // Access end strobes; each lasts one cycle
  wire rd_end;
  wire wr_end;
  assign rd_end = (state_q == ST_READ) && (state_d == ST_TURN);
  assign wr_end = (state_q == ST_WRITE) && (state_d == ST_IDLE);

  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  always @* begin
    state_d = state_q;
    tmr_load = 1'b0;
    tmr_count = `ASC_CNT_ZERO;
    // Supply loss overrides every state and aborts any access in
    // flight; the pins deselect at the next edge
    if (!supply_ok_i) begin
      state_d = ST_RET;
    end else begin
      case (state_q)
        ST_RET: begin
          state_d = ST_WAKE;
          tmr_load = 1'b1;
          tmr_count = cyc(`ASC_RD_CYC);
        end
        ST_WAKE: begin
          if (tmr_done) begin
            state_d = ST_IDLE;
          end
        end
        ST_IDLE: begin
          if (req_i) begin
            tmr_load = 1'b1;
            if (req_write_i) begin
              state_d = ST_WRITE;
              tmr_count = cyc(`ASC_WR_CYC);
            end else begin
              state_d = ST_READ;
              tmr_count = cyc(`ASC_RD_CYC);
            end
          end
        end
        ST_READ: begin
          if (tmr_done) begin
            state_d = ST_TURN;
            tmr_load = 1'b1;
            tmr_count = cyc(`ASC_TA_CYC);
          end
        end
        ST_WRITE: begin
          if (tmr_done) begin
            state_d = ST_IDLE;
          end
        end
        ST_TURN: begin
          if (tmr_done) begin
            state_d = ST_IDLE;
          end
        end
        default: begin
          state_d = ST_RET;
        end
      endcase
    end
  end

  // ****************************************************************
  // State and memory pin registers
  // ****************************************************************
  // Pins come from flops so no glitch can open a stray write
  always @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_q <= ST_RET;
      word_address_o <= {`ASC_AW{1'b0}};
      chip_select_low_o <= 1'b1;
      chip_select_high_o <= 1'b0;
      read_drive_enable_n_o <= 1'b1;
      write_strobe_n_o <= 1'b1;
      data_lines_o <= {`ASC_DW{1'b0}};
      data_oe_n_o <= 1'b1;
    end else begin
      state_q <= state_d;
      case (state_d)
        ST_READ: begin
          // Both selects active; strobe high, data released
          chip_select_low_o <= 1'b0;
          chip_select_high_o <= 1'b1;
          write_strobe_n_o <= 1'b1;
          data_oe_n_o <= 1'b1;
          read_drive_enable_n_o <= 1'b0;
          if (state_q == ST_IDLE) begin
            word_address_o <= req_addr_i;
          end
        end
        ST_WRITE: begin
          // Memory floats while the strobe is low, so we may drive
          chip_select_low_o <= 1'b0;
          chip_select_high_o <= 1'b1;
          read_drive_enable_n_o <= 1'b1;
          write_strobe_n_o <= 1'b0;
          data_oe_n_o <= 1'b0;
          if (state_q == ST_IDLE) begin
            word_address_o <= req_addr_i;
            data_lines_o <= req_wdata_i;
          end
        end
        default: begin
          // Deselect, strobe raised at the same edge ends write
          chip_select_low_o <= 1'b1;
          chip_select_high_o <= 1'b0;
          write_strobe_n_o <= 1'b1;
          read_drive_enable_n_o <= 1'b1;
          data_oe_n_o <= 1'b1;
        end
      endcase
    end
  end

  // ****************************************************************
  // Answer pulses
  // ****************************************************************
  // Read data is taken at the edge that ends the access, while the
  // memory still drives; the pins let go at that same edge, and the
  // memory's own release delay keeps the sampled word valid
  // A supply abort leaves READ or WRITE for RET, so no pulse follows
  always @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rd_data_o <= {`ASC_DW{1'b0}};
      rd_valid_o <= 1'b0;
      wr_done_o <= 1'b0;
    end else begin
      rd_valid_o <= rd_end;
      wr_done_o <= wr_end;
      if (rd_end) begin
        rd_data_o <= data_lines_i;
      end
    end
  end

endmodule // asc_ctrl

// File: bench/asc_mem_model.sv
// Behavioural 8K x 8 static memory facing the controller pins.
// Assumes the bench resolves the shared data wire from drive_o.
module asc_mem_model #(
  parameter int DLY = 0
) (
  // Memory pins
  input wire logic [12:0] word_address_i,
  input wire logic chip_select_low_i,
  input wire logic chip_select_high_i,
  input wire logic read_drive_enable_n_i,
  input wire logic write_strobe_n_i,
  input wire logic [7:0] data_lines_i,
  // Read side
  output logic [7:0] data_o,
  output logic drive_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem [0:8191];
  wire sel = !chip_select_low_i && chip_select_high_i;
  // No clock: cell follows the bus while the write is qualified
  always @* begin
    if (sel && !write_strobe_n_i) mem[word_address_i] = data_lines_i;
  end
  // Drive delayed by DLY to play a slow part; no inversion on return
  assign #(DLY) drive_o = sel && write_strobe_n_i && !read_drive_enable_n_i;
  assign #(DLY) data_o = mem[word_address_i];
endmodule // asc_mem_model

// File: bench/asc_ctrl_asserts.sv
// Pin protocol checker for the memory controller.
// Assumes one clock domain; bound to asc_ctrl below.
module asc_ctrl_asserts (
  // Clock, reset, supply
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  input wire logic supply_ok_i,
  // User side
  input wire logic req_ready_o,
  input wire logic [7:0] rd_data_o,
  input wire logic rd_valid_o,
  input wire logic wr_done_o,
  input wire logic retention_o,
  // Memory pins
  input wire logic chip_select_low_o,
  input wire logic chip_select_high_o,
  input wire logic read_drive_enable_n_o,
  input wire logic write_strobe_n_o,
  input wire logic data_oe_n_o,
  input wire logic [7:0] data_lines_i
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!resetn_i);
  logic [5:0] ok_cnt_q;
  // Cycles since supply came back, saturating
  always @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) ok_cnt_q <= 6'h00;
    else if (!supply_ok_i) ok_cnt_q <= 6'h00;
    else if (ok_cnt_q != 6'h3f) ok_cnt_q <= ok_cnt_q + 6'h01;
  end
  a_read_strobe: assert property (
    !read_drive_enable_n_o |-> write_strobe_n_o) else $error("strobe in read");
  a_bus_release: assert property (
    !read_drive_enable_n_o |-> data_oe_n_o && $past(data_oe_n_o))
    else $error("bus clash");
  a_write_len: assert property (
    disable iff (!resetn_i || !supply_ok_i)
    $fell(write_strobe_n_o) |-> ##11 (write_strobe_n_o && wr_done_o))
    else $error("write pulse length");
  a_write_sel: assert property (
    !write_strobe_n_o |-> !chip_select_low_o && chip_select_high_o
    && !data_oe_n_o) else $error("write unqualified");
  a_oe_stable: assert property (
    !write_strobe_n_o |-> $stable(read_drive_enable_n_o))
    else $error("enable moved in write");
  a_read_data: assert property (
    disable iff (!resetn_i || !supply_ok_i)
    $fell(read_drive_enable_n_o) |-> ##21 (rd_valid_o
    && rd_data_o == $past(data_lines_i))) else $error("read answer");
  a_retain_desel: assert property (
    retention_o |-> chip_select_low_o && !chip_select_high_o)
    else $error("selected in retention");
  a_fail_desel: assert property (
    !supply_ok_i |=> chip_select_low_o && !chip_select_high_o)
    else $error("late deselect");
  a_wake_wait: assert property (
    chip_select_high_o |-> ok_cnt_q >= 6'h14) else $error("early access");
  a_ready_idle: assert property (
    req_ready_o |-> supply_ok_i && chip_select_low_o && write_strobe_n_o)
    else $error("ready while busy");
endmodule // asc_ctrl_asserts

bind asc_ctrl asc_ctrl_asserts chk (.clk_sys_i, .resetn_i, .supply_ok_i,
  .req_ready_o, .rd_data_o, .rd_valid_o, .wr_done_o, .retention_o,
  .chip_select_low_o, .chip_select_high_o, .read_drive_enable_n_o,
  .write_strobe_n_o, .data_oe_n_o, .data_lines_i);

// File: bench/asc_ctrl_tb.sv
// Self-checking bench for asc_ctrl against a behavioural memory.
// Assumes the hand-over timing at 40 MHz.
module asc_ctrl_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_sys_i, resetn_i, req_i, req_write_i, supply_ok_i, tog_q = 0;
  logic [12:0] req_addr_i;
  logic [7:0] req_wdata_i;
  wire req_ready_o, rd_valid_o, wr_done_o, retention_o, cs_l, cs_h, oe_n;
  wire we_n, doe_n, m_drv;
  wire [12:0] addr;
  wire [7:0] rd_data_o, dout, m_dat, dwire;
  int fails = 0, checked = 0, cyc = 0;
  // Released wire shows a pattern that flips each cycle, never old data
  assign dwire = m_drv ? m_dat : (!doe_n ? dout : 8'hc3 ^ {8{tog_q}});
  asc_ctrl uut (.clk_sys_i, .resetn_i, .req_i, .req_write_i, .req_addr_i,
    .req_wdata_i, .req_ready_o, .rd_data_o, .rd_valid_o, .wr_done_o,
    .supply_ok_i, .retention_o, .word_address_o(addr),
    .chip_select_low_o(cs_l), .chip_select_high_o(cs_h),
    .read_drive_enable_n_o(oe_n), .write_strobe_n_o(we_n),
    .data_lines_o(dout), .data_oe_n_o(doe_n), .data_lines_i(dwire));
  asc_mem_model #(.DLY(100)) mem (.word_address_i(addr),
    .chip_select_low_i(cs_l), .chip_select_high_i(cs_h),
    .read_drive_enable_n_i(oe_n), .write_strobe_n_i(we_n),
    .data_lines_i(dwire), .data_o(m_dat), .drive_o(m_drv));
  initial begin
    clk_sys_i = 1'b0;
    forever #12.5 clk_sys_i = ~clk_sys_i;
  end
  task end_of_test;
    if (fails == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Hang guard: the whole run needs well under a thousand cycles
  always @(posedge clk_sys_i) begin
    cyc <= cyc + 1;
    tog_q <= !tog_q;
    if (cyc == 3000) begin
      fails++;
      end_of_test();
    end
  end
  task chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (exp !== got) begin
      fails++;
      $display("MISMATCH %s exp %h got %h", what, exp, got);
    end
  endtask
  // One request; lat counts cycles from the take edge to the answer
  task xfer(input logic w, input logic [12:0] a, input logic [7:0] d,
    output int lat, output logic [7:0] rd);
    @(negedge clk_sys_i);
    while (req_ready_o !== 1'b1) @(negedge clk_sys_i);
    @(posedge clk_sys_i);
    req_i <= 1'b1;
    req_write_i <= w;
    req_addr_i <= a;
    req_wdata_i <= d;
    @(posedge clk_sys_i);
    req_i <= 1'b0;
    lat = 0;
    // First look falls in the take cycle itself, which counts as zero
    @(negedge clk_sys_i);
    while (lat < 40 && (w ? wr_done_o : rd_valid_o) !== 1'b1) begin
      @(negedge clk_sys_i);
      lat++;
    end
    rd = rd_data_o;
  endtask
  task sc_access;
    int lat;
    logic [7:0] rd;
    xfer(1'b1, 13'h1fff, 8'ha5, lat, rd);
    chk("write_lat", 16'h000b, 16'(lat));
    xfer(1'b1, 13'h0000, 8'h5a, lat, rd);
    chk("write_b2b_lat", 16'h000b, 16'(lat));
    xfer(1'b0, 13'h1fff, 8'h00, lat, rd);
    chk("read_lat", 16'h0015, 16'(lat));
    chk("read_top", 16'h00a5, {8'h00, rd});
    xfer(1'b0, 13'h0000, 8'h00, lat, rd);
    chk("read_bottom", 16'h005a, {8'h00, rd});
  endtask
  task sc_supply_loss;
    int lat, n;
    logic [7:0] rd;
    fork
      begin
        repeat (8) @(posedge clk_sys_i);
        supply_ok_i <= 1'b0;
      end
      xfer(1'b0, 13'h0001, 8'h00, lat, rd);
    join
    chk("abort_no_answer", 16'h0028, 16'(lat));
    chk("retention_pins", 16'h0006, {13'h0, retention_o, cs_l, cs_h});
    @(posedge clk_sys_i);
    supply_ok_i <= 1'b1;
    n = 0;
    while (req_ready_o !== 1'b1 && n < 60) begin
      @(negedge clk_sys_i);
      n++;
    end
    chk("wake_wait", 16'h0001, {15'h0, n >= 20 && n < 60});
    xfer(1'b0, 13'h1fff, 8'h00, lat, rd);
    chk("kept_data", 16'h00a5, {8'h00, rd});
  endtask
  initial begin
    resetn_i = 1'b0;
    req_i = 1'b0;
    req_write_i = 1'b0;
    req_addr_i = 13'h0000;
    req_wdata_i = 8'h00;
    supply_ok_i = 1'b1;
    repeat (8) @(posedge clk_sys_i);
    resetn_i <= 1'b1;
    sc_access();
    sc_supply_loss();
    end_of_test();
  end
endmodule // asc_ctrl_tb
